// file: adcr_regs.sv
// Operation
// - Click enable starts tone; hardware clears it after programmed periods.
// - Amplitude code 000 lowest, 100 medium reset, 111 highest.
// - Frequency codes 000..111 give 62.5Hz up to 8kHz; reset 100.
// - Length codes 0..3 give 2,4,6,8 periods; others 32.
// - Gain flags read 1 when applied gain equals programmed volume.
// - Gain steps 0.5dB each frame, or each second frame.
// - Codec power-down bit 1 powers codec down; reset 1.
// - Driver bit 0 bypasses headphone driver, 1 enables; reset 0.
// - Converter power-down bit 1 powers converter down; reset 1.
// - Virtual ground amp bit 1 powers it down; reset 1.
// - Power-down-done flag reads 1 once converter is down; reset 1.
// - Bass boost enable bit, reset 0.
// - De-emphasis enable bit, reset 0.
// - Linking: 00/11 independent, 01 right to left, 10 left to right.
// - Reference rate bit: 0 is 48kHz, 1 is 44.1kHz.
// - Transfer mode bit: 0 continuous, 1 256-s mode.
// - Role bit: 0 slave, 1 master; far end takes opposite role.
// - Overflow flags set on saturation, cleared by reading register.
// - Fixed read-only revision code in low three bits.
// - Boost coefficient shared by left and right, 16-bit signed, reset 27619.
// - Volume code 1111111 is 0dB, each step lower 0.5dB, 0 is -63.5dB; codes 1..126 are used here directly as attenuation steps.
`include "adcr_map.svh"
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module adcr_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Fill side
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  input  wire logic [WIDTH-1:0] wr_data,
  // Drain side
  output logic                  rd_valid,
  input  wire logic             rd_ready,
  output logic      [WIDTH-1:0] rd_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wptr_r;
  logic [AW:0]      rptr_r;
  wire              full  = (wptr_r[AW] != rptr_r[AW]) && (wptr_r[AW-1:0] == rptr_r[AW-1:0]);
  wire              empty = (wptr_r == rptr_r);
  wire              push  = wr_valid && !full;
  wire              pop   = rd_ready && !empty;

  assign wr_ready = !full;
  assign rd_valid = !empty;
  assign rd_data  = mem_r[rptr_r[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wptr_r[AW-1:0]] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wptr_r <= '0;
      rptr_r <= '0;
    end else begin
      if (push) begin
        wptr_r <= wptr_r + 1'b1;
      end
      if (pop) begin
        rptr_r <= rptr_r + 1'b1;
      end
    end
  end
endmodule : adcr_fifo

////////////////////////////////////////////////////////////////////////////////
module adcr_regs #(
  parameter int          CLICK_HALF_CYC = `ADCR_CLICK_HALF_CYC,
  // Arbitrary revision value
  parameter logic [2:0]  REVISION_CODE  = 3'h5
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Register port
  input  wire logic [5:0]  reg_addr,
  input  wire logic        reg_wr_en,
  input  wire logic [15:0] reg_wr_data,
  input  wire logic        reg_rd_en,
  output logic      [15:0] reg_rd_data,
  output logic             reg_rd_valid,
  // Audio input stream
  input  wire logic        in_valid,
  output logic             in_ready,
  input  wire logic [15:0] in_left,
  input  wire logic [15:0] in_right,
  // Audio output samples
  output logic             out_valid,
  output logic      [15:0] out_left,
  output logic      [15:0] out_right,
  // Frame clock pin
  input  wire logic        frame_clk_in,
  output logic             frame_clk_out,
  output logic             frame_clk_oe,
  // Analog and mode controls
  output logic             codec_powered_down,
  output logic             converter_powered_down,
  output logic             vg_amp_powered_down,
  output logic             headphone_driver_on,
  output logic             boost_on,
  output logic             deemphasis_on,
  output logic             ref_rate_44k1,
  output logic             transfer_256s,
  output logic             role_master,
  output logic             click_active
);
  ////////////////////////////////////////////////////////////////////////////
  // Helper functions
  function automatic logic [6:0] vol_to_att(input logic [6:0] code);
    logic [6:0] att;
    att = code;
    if (code == 7'h7f) begin
      att = 7'h00;
    end else if (code == 7'h00) begin
      att = 7'h7f;
    end
    return att;
  endfunction : vol_to_att

  function automatic logic [16:0] process_sample(
    input logic signed [15:0] sample,
    input logic signed [15:0] coef,
    input logic               boost,
    input logic        [6:0]  att,
    input logic signed [15:0] click,
    input logic               mute
  );
    logic signed [15:0] g;
    logic signed [31:0] prod;
    logic signed [17:0] boost_term;
    logic signed [17:0] sum;
    logic        [16:0] res;
    g          = sample >>> (att / 7'd12);
    prod       = g * coef;
    boost_term = boost ? {{3{prod[31]}}, prod[31:17]} : 18'sh00000;
    sum        = {{2{g[15]}}, g} + boost_term + {{2{click[15]}}, click};
    res        = {1'b0, sum[15:0]};
    if (sum[17:15] != 3'h0 && sum[17:15] != 3'h7) begin
      res = sum[17] ? {1'b1, 16'h8000} : {1'b1, 16'h7fff};
    end
    if (mute) begin
      res = 17'h00000;
    end
    return res;
  endfunction : process_sample

  function automatic logic [6:0] click_half_periods(input logic [3:0] len);
    logic [6:0] n;
    n = 7'd64;
    if (len == 4'h0) begin
      n = 7'd4;
    end else if (len == 4'h1) begin
      n = 7'd8;
    end else if (len == 4'h2) begin
      n = 7'd12;
    end else if (len == 4'h3) begin
      n = 7'd16;
    end
    return n;
  endfunction : click_half_periods

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  logic        click_en_r;
  logic [2:0]  click_amp_r;
  logic [2:0]  click_frq_r;
  logic [3:0]  click_len_r;
  logic        step_rate_r;
  logic        lsettled_r;
  logic        rsettled_r;
  logic        codec_pd_r;
  logic        drv_on_r;
  logic        conv_pd_r;
  logic        vg_pd_r;
  logic        pd_done_r;
  logic        boost_r;
  logic        deemp_r;
  logic [1:0]  link_r;
  logic        ref_r;
  logic        xfm_r;
  logic        role_r;
  logic        lovf_r;
  logic        rovf_r;
  logic [15:0] coef_r;
  logic [15:0] volume_r;

  wire wr_vol    = reg_wr_en && (reg_addr == `ADCR_OFS_VOLUME);
  wire wr_click  = reg_wr_en && (reg_addr == `ADCR_OFS_CLICK);
  wire wr_power  = reg_wr_en && (reg_addr == `ADCR_OFS_POWER);
  wire wr_status = reg_wr_en && (reg_addr == `ADCR_OFS_STATUS);
  wire wr_coef   = reg_wr_en && (reg_addr == `ADCR_OFS_COEF);
  wire rd_status = reg_rd_en && (reg_addr == `ADCR_OFS_STATUS);

  ////////////////////////////////////////////////////////////////////////////
  // Frame timing
  logic [11:0] frame_cnt_r;
  logic        frame_pin_r;
  logic        frame_pin_prev_r;
  logic        step_phase_r;
  wire  [11:0] frame_len  = ref_r ? 12'(`ADCR_FRAME_44K1_CYC) : 12'(`ADCR_FRAME_48K_CYC);
  wire         div_tick   = (frame_cnt_r == 12'h000);
  wire         frame_tick = role_r ? div_tick : (frame_pin_r && !frame_pin_prev_r);
  wire         step_tick  = frame_tick && (!step_rate_r || step_phase_r);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      frame_cnt_r      <= 12'h000;
      frame_clk_out    <= 1'b0;
      frame_pin_r      <= 1'b0;
      frame_pin_prev_r <= 1'b0;
      step_phase_r     <= 1'b0;
    end else begin
      frame_cnt_r      <= div_tick ? frame_len - 12'h001 : frame_cnt_r - 12'h001;
      frame_clk_out    <= role_r && (frame_cnt_r >= {1'b0, frame_len[11:1]});
      frame_pin_r      <= frame_clk_in;
      frame_pin_prev_r <= frame_pin_r;
      step_phase_r     <= frame_tick ? !step_phase_r : step_phase_r;
    end
  end
  assign frame_clk_oe = role_r;

  ////////////////////////////////////////////////////////////////////////////
  // Soft-stepped gain
  logic [6:0] att_l_r;
  logic [6:0] att_r_r;
  wire  [6:0] code_l   = (link_r == 2'b01) ? volume_r[6:0] : volume_r[14:8];
  wire  [6:0] code_r   = (link_r == 2'b10) ? volume_r[14:8] : volume_r[6:0];
  wire  [6:0] tgt_l    = vol_to_att(code_l);
  wire  [6:0] tgt_r    = vol_to_att(code_r);
  wire  [6:0] att_l_nxt = (att_l_r < tgt_l) ? att_l_r + 7'h01 :
                          (att_l_r > tgt_l) ? att_l_r - 7'h01 : att_l_r;
  wire  [6:0] att_r_nxt = (att_r_r < tgt_r) ? att_r_r + 7'h01 :
                          (att_r_r > tgt_r) ? att_r_r - 7'h01 : att_r_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      att_l_r    <= 7'h00;
      att_r_r    <= 7'h00;
      lsettled_r <= 1'b0;
      rsettled_r <= 1'b0;
    end else begin
      if (step_tick) begin
        att_l_r <= att_l_nxt;
        att_r_r <= att_r_nxt;
      end
      lsettled_r <= !wr_vol && (att_l_r == tgt_l);
      rsettled_r <= !wr_vol && (att_r_r == tgt_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Click tone generator
  adcr_pkg::adcr_click_state_t click_st_r;
  logic [23:0]                 click_cnt_r;
  logic [6:0]                  click_halves_r;
  logic                        click_phase_r;
  // half period doubles per lower code
  wire  [23:0] click_half = 24'(CLICK_HALF_CYC) << (3'h7 - click_frq_r);
  wire         click_edge = (click_cnt_r == 24'h000000);
  wire         click_done = (click_st_r == adcr_pkg::ADCR_CLICK_RUN) && click_edge &&
                            (click_halves_r == 7'h01);
  wire  [15:0] click_lvl  = {2'b00, {1'b0, click_amp_r} + 4'h1, 10'h000};
  wire  [15:0] click_wave = click_phase_r ? click_lvl : 16'h0000 - click_lvl;
  wire  [15:0] click_mix  = (click_st_r == adcr_pkg::ADCR_CLICK_RUN) ? click_wave : 16'h0000;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      click_st_r     <= adcr_pkg::ADCR_CLICK_IDLE;
      click_cnt_r    <= 24'h000000;
      click_halves_r <= 7'h00;
      click_phase_r  <= 1'b0;
    end else begin
      case (click_st_r)
        adcr_pkg::ADCR_CLICK_IDLE: begin
          if (click_en_r) begin
            click_st_r     <= adcr_pkg::ADCR_CLICK_RUN;
            click_cnt_r    <= click_half - 24'h000001;
            click_halves_r <= click_half_periods(click_len_r);
            click_phase_r  <= 1'b1;
          end
        end
        adcr_pkg::ADCR_CLICK_RUN: begin
          if (!click_en_r || click_done) begin
            click_st_r <= adcr_pkg::ADCR_CLICK_IDLE;
          end else if (click_edge) begin
            click_cnt_r    <= click_half - 24'h000001;
            click_halves_r <= click_halves_r - 7'h01;
            click_phase_r  <= !click_phase_r;
          end else begin
            click_cnt_r <= click_cnt_r - 24'h000001;
          end
        end
        default: begin
          click_st_r <= adcr_pkg::ADCR_CLICK_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Playback path
  logic        fifo_valid;
  logic [31:0] fifo_data;
  wire         powered = !codec_pd_r && !conv_pd_r;
  wire         pop     = frame_tick && powered && fifo_valid;
  wire  [16:0] proc_l  = process_sample(fifo_data[31:16], coef_r, boost_r, att_l_r,
                                        click_mix, volume_r[`ADCR_VOL_LMUTE_BIT]);
  wire  [16:0] proc_r  = process_sample(fifo_data[15:0], coef_r, boost_r, att_r_r,
                                        click_mix, volume_r[`ADCR_VOL_RMUTE_BIT]);

  adcr_fifo #(
    .WIDTH (32),
    .DEPTH (8)
  ) u_fifo (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .wr_valid (in_valid),
    .wr_ready (in_ready),
    .wr_data  ({in_left, in_right}),
    .rd_valid (fifo_valid),
    .rd_ready (pop),
    .rd_data  (fifo_data)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_valid <= 1'b0;
      out_left  <= 16'h0000;
      out_right <= 16'h0000;
    end else begin
      out_valid <= pop;
      if (pop) begin
        out_left  <= proc_l[15:0];
        out_right <= proc_r[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes and status
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      click_en_r  <= 1'b0;
      click_amp_r <= `ADCR_RST_CLK_AMP;
      click_frq_r <= `ADCR_RST_CLK_FRQ;
      click_len_r <= `ADCR_RST_CLK_LEN;
      step_rate_r <= 1'b0;
      codec_pd_r  <= 1'b1;
      drv_on_r    <= 1'b0;
      conv_pd_r   <= 1'b1;
      vg_pd_r     <= 1'b1;
      pd_done_r   <= 1'b1;
      boost_r     <= 1'b0;
      deemp_r     <= 1'b0;
      link_r      <= 2'b00;
      ref_r       <= 1'b0;
      xfm_r       <= 1'b0;
      role_r      <= 1'b0;
      lovf_r      <= 1'b0;
      rovf_r      <= 1'b0;
      coef_r      <= `ADCR_RST_COEF;
      volume_r    <= `ADCR_RST_VOLUME;
    end else begin
      if (wr_click) begin
        click_en_r  <= reg_wr_data[`ADCR_CLK_EN_BIT];
        click_amp_r <= reg_wr_data[`ADCR_CLK_AMP_LSB +: 3];
        click_frq_r <= reg_wr_data[`ADCR_CLK_FRQ_LSB +: 3];
        click_len_r <= reg_wr_data[`ADCR_CLK_LEN_LSB +: 4];
        step_rate_r <= reg_wr_data[`ADCR_CLK_RATE_BIT];
      end else if (click_done) begin
        click_en_r <= 1'b0;
      end
      if (wr_power) begin
        codec_pd_r <= reg_wr_data[`ADCR_PWR_CODEC_BIT];
        drv_on_r   <= reg_wr_data[`ADCR_PWR_DRV_BIT];
        conv_pd_r  <= reg_wr_data[`ADCR_PWR_CONV_BIT];
        vg_pd_r    <= reg_wr_data[`ADCR_PWR_VG_BIT];
        boost_r    <= reg_wr_data[`ADCR_PWR_BOOST_BIT];
        deemp_r    <= reg_wr_data[`ADCR_PWR_DEEMP_BIT];
      end
      pd_done_r <= conv_pd_r && (pd_done_r || frame_tick);
      if (wr_status) begin
        link_r <= reg_wr_data[`ADCR_ST_LINK_LSB +: 2];
        ref_r  <= reg_wr_data[`ADCR_ST_REF_BIT];
        xfm_r  <= reg_wr_data[`ADCR_ST_XFM_BIT];
        role_r <= reg_wr_data[`ADCR_ST_ROLE_BIT];
      end
      lovf_r <= (pop && proc_l[16]) || (lovf_r && !rd_status);
      rovf_r <= (pop && proc_r[16]) || (rovf_r && !rd_status);
      if (wr_coef) begin
        coef_r <= reg_wr_data;
      end
      if (wr_vol) begin
        volume_r <= reg_wr_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    if (reg_addr == `ADCR_OFS_VOLUME) begin
      rd_mux = volume_r;
    end else if (reg_addr == `ADCR_OFS_CLICK) begin
      rd_mux = {click_en_r, click_amp_r, 1'b0, click_frq_r, click_len_r,
                lsettled_r, rsettled_r, step_rate_r, 1'b0};
    end else if (reg_addr == `ADCR_OFS_POWER) begin
      rd_mux = `ADCR_PWR_FIXED;
      rd_mux[`ADCR_PWR_CODEC_BIT] = codec_pd_r;
      rd_mux[`ADCR_PWR_DRV_BIT]   = drv_on_r;
      rd_mux[`ADCR_PWR_CONV_BIT]  = conv_pd_r;
      rd_mux[`ADCR_PWR_VG_BIT]    = vg_pd_r;
      rd_mux[`ADCR_PWR_DONE_BIT]  = pd_done_r;
      rd_mux[`ADCR_PWR_BOOST_BIT] = boost_r;
      rd_mux[`ADCR_PWR_DEEMP_BIT] = deemp_r;
    end else if (reg_addr == `ADCR_OFS_STATUS) begin
      rd_mux = {link_r, ref_r, xfm_r, role_r, 3'h0, lovf_r, rovf_r, 3'h0, REVISION_CODE};
    end else if (reg_addr == `ADCR_OFS_COEF) begin
      rd_mux = coef_r;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rd_valid <= 1'b0;
      reg_rd_data  <= 16'h0000;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rd_data <= rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control outputs
  assign codec_powered_down     = codec_pd_r;
  assign converter_powered_down = conv_pd_r;
  assign vg_amp_powered_down    = vg_pd_r;
  assign headphone_driver_on    = drv_on_r;
  assign boost_on               = boost_r;
  assign deemphasis_on          = deemp_r;
  assign ref_rate_44k1          = ref_r;
  assign transfer_256s          = xfm_r;
  assign role_master            = role_r;
  assign click_active           = (click_st_r == adcr_pkg::ADCR_CLICK_RUN);
endmodule : adcr_regs

`default_nettype wire

// file: adcr_map.svh
`ifndef ADCR_MAP_SVH
`define ADCR_MAP_SVH

// Register offsets
`define ADCR_OFS_VOLUME      6'h02
`define ADCR_OFS_CLICK       6'h04
`define ADCR_OFS_POWER       6'h05
`define ADCR_OFS_STATUS      6'h06
`define ADCR_OFS_COEF        6'h07

// Field positions
`define ADCR_CLK_EN_BIT      15
`define ADCR_CLK_AMP_LSB     12
`define ADCR_CLK_FRQ_LSB     8
`define ADCR_CLK_LEN_LSB     4
`define ADCR_CLK_LGAF_BIT    3
`define ADCR_CLK_RGAF_BIT    2
`define ADCR_CLK_RATE_BIT    1
`define ADCR_PWR_CODEC_BIT   15
`define ADCR_PWR_DRV_BIT     12
`define ADCR_PWR_CONV_BIT    10
`define ADCR_PWR_VG_BIT      8
`define ADCR_PWR_DONE_BIT    6
`define ADCR_PWR_BOOST_BIT   1
`define ADCR_PWR_DEEMP_BIT   0
`define ADCR_ST_LINK_LSB     14
`define ADCR_ST_REF_BIT      13
`define ADCR_ST_XFM_BIT      12
`define ADCR_ST_ROLE_BIT     11
`define ADCR_ST_LOVF_BIT     7
`define ADCR_ST_ROVF_BIT     6
`define ADCR_VOL_LMUTE_BIT   15
`define ADCR_VOL_LLVL_LSB    8
`define ADCR_VOL_RMUTE_BIT   7
`define ADCR_VOL_RLVL_LSB    0

// Reset values
`define ADCR_RST_VOLUME      16'hffff
`define ADCR_RST_CLK_AMP     3'h4
`define ADCR_RST_CLK_FRQ     3'h4
`define ADCR_RST_CLK_LEN     4'h1
`define ADCR_RST_COEF        16'h6be3
`define ADCR_PWR_FIXED       16'h2aa0

// Timing
`define ADCR_CLK_HZ          125000000
`define ADCR_CLK_PERIOD_NS   8
`define ADCR_RATE_48K_HZ     48000
`define ADCR_RATE_44K1_HZ    44100
`define ADCR_FRAME_48K_CYC   (`ADCR_CLK_HZ / `ADCR_RATE_48K_HZ)
`define ADCR_FRAME_44K1_CYC  (`ADCR_CLK_HZ / `ADCR_RATE_44K1_HZ)
`define ADCR_CLICK_8K_HALF_NS 62500
`define ADCR_CLICK_HALF_CYC  (`ADCR_CLICK_8K_HALF_NS / `ADCR_CLK_PERIOD_NS)

`endif

// file: adcr_pkg.sv
`default_nettype none
package adcr_pkg;
  typedef enum logic [0:0] {
    ADCR_CLICK_IDLE = 1'b0,
    ADCR_CLICK_RUN  = 1'b1
  } adcr_click_state_t;
  typedef logic signed [15:0] adcr_sample_t;
endpackage : adcr_pkg
`default_nettype wire

// file: adcr_checker.sv
`default_nettype none
module adcr_checker (
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // Register port
  input wire logic [5:0]  reg_addr,
  input wire logic        reg_wr_en,
  input wire logic [15:0] reg_wr_data,
  // Outputs watched
  input wire logic        out_valid,
  input wire logic        frame_clk_out,
  input wire logic        frame_clk_oe,
  input wire logic        codec_powered_down,
  input wire logic        converter_powered_down,
  input wire logic        headphone_driver_on,
  input wire logic        boost_on,
  input wire logic        role_master,
  input wire logic        click_active
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire w04 = reg_wr_en && reg_addr == 6'h04;
  wire w05 = reg_wr_en && reg_addr == 6'h05;
  wire w06 = reg_wr_en && reg_addr == 6'h06;
  ////////////////////////////////////////////////////////////////////////////
  property p_codec; w05 |=> codec_powered_down == $past(reg_wr_data[15]); endproperty
  a_codec: assert property (p_codec) else $error("codec power bit wrong");
  property p_conv; w05 |=> converter_powered_down == $past(reg_wr_data[10]); endproperty
  a_conv: assert property (p_conv) else $error("converter power bit wrong");
  property p_drv; w05 |=> headphone_driver_on == $past(reg_wr_data[12]); endproperty
  a_drv: assert property (p_drv) else $error("driver bit wrong");
  property p_boost; w05 |=> boost_on == $past(reg_wr_data[1]); endproperty
  a_boost: assert property (p_boost) else $error("boost bit wrong");
  property p_role; w06 |=> role_master == $past(reg_wr_data[11]); endproperty
  a_role: assert property (p_role) else $error("role bit wrong");
  property p_oe; frame_clk_oe == role_master; endproperty
  a_oe: assert property (p_oe) else $error("pin enable differs from role");
  property p_fclk; !role_master [*2] |-> !frame_clk_out; endproperty
  a_fclk: assert property (p_fclk) else $error("frame clock driven as slave");
  property p_click; w04 && reg_wr_data[15] |-> ##2 click_active; endproperty
  a_click: assert property (p_click) else $error("click did not start");
  property p_idle; codec_powered_down [*2] |-> !out_valid; endproperty
  a_idle: assert property (p_idle) else $error("output while powered down");
endmodule : adcr_checker
bind adcr_regs adcr_checker i_adcr_checker (.clk, .sys_rst, .reg_addr, .reg_wr_en,
  .reg_wr_data, .out_valid, .frame_clk_out, .frame_clk_oe, .codec_powered_down,
  .converter_powered_down, .headphone_driver_on, .boost_on, .role_master, .click_active);
`default_nettype wire

// file: adcr_far_end.sv
`default_nettype none
module adcr_far_end #(
  parameter int HALF = 32
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Role of the device
  input  wire logic dev_master,
  // Frame clock pin
  output logic      frame_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  int   cnt_r;
  logic lvl_r;
  always_ff @(posedge clk) begin
    if (sys_rst || dev_master || cnt_r == HALF - 1) begin
      cnt_r <= 0;
    end else begin
      cnt_r <= cnt_r + 1;
    end
    lvl_r <= (sys_rst || dev_master) ? 1'b0 : lvl_r ^ (cnt_r == HALF - 1);
  end
  assign frame_clk = lvl_r;
endmodule : adcr_far_end
`default_nettype wire

// file: adcr_regs_bench.sv
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fails++; \
  $display("[ERR] %0t got %h want %h", $time, a, e); end end
module adcr_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FP = 64;
  logic clk = 1'b0, sys_rst = 1'b1, reg_wr_en = 1'b0, reg_rd_en = 1'b0, in_valid = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic [15:0] reg_wr_data = 16'h0000, in_left = 16'h0000, in_right = 16'h0000;
  logic [15:0] reg_rd_data, out_left, out_right;
  logic reg_rd_valid, in_ready, out_valid, frame_clk_out, frame_clk_oe, far_clk;
  logic codec_powered_down, converter_powered_down, vg_amp_powered_down;
  logic headphone_driver_on, boost_on, deemphasis_on, ref_rate_44k1;
  logic transfer_256s, role_master, click_active;
  int fails = 0, tests_run = 0, cyc = 0, k, w, ng = 0;
  logic [31:0] got [8];
  wire logic fclk = frame_clk_oe ? frame_clk_out : far_clk;
  // Arbitrary revision value
  adcr_regs #(.CLICK_HALF_CYC(4), .REVISION_CODE(3'h3)) i_adcr_regs (.clk, .sys_rst,
    .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en, .reg_rd_data, .reg_rd_valid,
    .in_valid, .in_ready, .in_left, .in_right, .out_valid, .out_left, .out_right,
    .frame_clk_in(fclk), .frame_clk_out, .frame_clk_oe, .codec_powered_down,
    .converter_powered_down, .vg_amp_powered_down, .headphone_driver_on, .boost_on,
    .deemphasis_on, .ref_rate_44k1, .transfer_256s, .role_master, .click_active);
  adcr_far_end #(.HALF(FP / 2)) i_adcr_far_end (.clk, .sys_rst, .dev_master(frame_clk_oe),
    .frame_clk(far_clk));
  initial forever #4 clk = ~clk;
  // Catch the first eight output pulses
  always @(negedge clk) begin
    if (out_valid === 1'b1 && ng < 8) begin
      got[ng] = {out_left, out_right};
      ng++;
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] smp(input int i);
    return (i < 4) ? 16'(256 * (i + 1)) : 16'h7000;
  endfunction : smp
  function automatic logic [15:0] bst(input logic [15:0] s);
    int v;
    v = int'($signed(s));
    v = v + ((v * 27619) >>> 17);
    return (v > 32767) ? 16'h7fff : v[15:0];
  endfunction : bst
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr_en <= 1'b1;
    @(posedge clk);
    reg_wr_en <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [5:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge clk);
    reg_rd_en <= 1'b0;
    #1;
    `CHK({reg_rd_valid, reg_rd_data}, {1'b1, e})
  endtask : rdc
  task automatic click(input logic [2:0] f, input logic [3:0] l, input int per);
    int n, ex;
    ex = 2 * per * (4 << (7 - f));
    wr(6'h04, {4'hf, 1'b0, f, l, 4'h0});
    n = 0;
    @(posedge clk);
    #1;
    while (click_active === 1'b1 && n < 9000) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK(n, ex)
    rdc(6'h04, {4'h7, 1'b0, f, l, 4'hc});
  endtask : click
  task automatic final_report();
    $display("tests_run %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [5:0] ra [6] = '{6'h01, 6'h02, 6'h04, 6'h05, 6'h06, 6'h07};
    logic [15:0] rv [6] = '{16'h0000, 16'hffff, 16'h441c, 16'hafe0, 16'h0003, 16'h6be3};
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 6; i++) rdc(ra[i], rv[i]);
    wr(6'h01, 16'hff00);
    rdc(6'h01, 16'h0000);
    wr(6'h07, 16'h8001);
    rdc(6'h07, 16'h8001);
    wr(6'h07, 16'h6be3);
    wr(6'h05, 16'hbfa3);
    rdc(6'h05, 16'hbfe3);
    `CHK({boost_on, deemphasis_on, headphone_driver_on}, 3'h7)
    wr(6'h06, 16'hf800);
    rdc(6'h06, 16'hf803);
    `CHK({ref_rate_44k1, transfer_256s, role_master, frame_clk_oe}, 4'hf)
    wr(6'h06, 16'h0000);
    $display("registers done");
    for (int f = 0; f < 8; f++) click(f[2:0], 4'h0, 2);
    for (int l = 0; l < 5; l++) click(3'h7, l[3:0], l < 4 ? 2 * l + 2 : 32);
    click(3'h7, 4'hf, 32);
    $display("click done");
    wr(6'h02, 16'h7f7f);
    k = 0;
    for (int i = 0; i < 9; i++) begin
      @(posedge clk);
      in_valid <= 1'b1;
      in_left <= smp(i);
      in_right <= smp(i) + 16'h0001;
      #1;
      if (in_ready !== 1'b1) break;
      k++;
    end
    @(posedge clk);
    in_valid <= 1'b0;
    `CHK(k, 8)
    wr(6'h05, 16'h3aa2);
    rdc(6'h05, 16'h3aa2);
    `CHK({codec_powered_down, converter_powered_down, vg_amp_powered_down}, 3'h0)
    w = 0;
    while (ng < 8 && w < 1000) begin
      @(posedge clk);
      w++;
    end
    `CHK(ng, 8)
    for (int i = 0; i < 8; i++) `CHK(got[i], {bst(smp(i)), bst(smp(i) + 16'h0001)})
    `CHK(in_ready, 1'b1)
    rdc(6'h06, 16'h00c3);
    rdc(6'h06, 16'h0003);
    $display("stream done");
    wr(6'h02, 16'h0404);
    rdc(6'h04, 16'h77f0);
    repeat (2 * FP) @(posedge clk);
    rdc(6'h04, 16'h77f0);
    repeat (4 * FP) @(posedge clk);
    rdc(6'h04, 16'h77fc);
    wr(6'h04, 16'h77f2);
    wr(6'h02, 16'h0808);
    repeat (5 * FP) @(posedge clk);
    rdc(6'h04, 16'h77f2);
    repeat (6 * FP) @(posedge clk);
    rdc(6'h04, 16'h77fe);
    $display("gain done");
    final_report();
  end
endmodule : adcr_regs_bench
`default_nettype wire
